// [ipa_pkg.sv]
// package of the indirect pointer addressing unit: widths, operand map, modes
// assumes a 12-bit byte-addressed data space and an 8-bit data path
package ipa_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int unsigned IPA_AW    = 12;
   localparam int unsigned IPA_DW    = 8;
   localparam int unsigned IPA_HI_W  = IPA_AW - IPA_DW;
   localparam int unsigned IPA_NPAIR = 3;

   // ------------------------------------------------------------
   // operand map: each pair owns a group of seven addresses that
   // counts down from its plain operand
   // ------------------------------------------------------------
   localparam logic [11:0] IPA_OPND_ONE_ADDR = 12'hFE7;
   localparam logic [11:0] IPA_GROUP_STRIDE  = 12'h008;
   localparam logic [11:0] IPA_GROUP_SIZE    = 12'h007;
   localparam logic [11:0] IPA_PTR_RESET     = 12'h000;

   typedef enum logic [2:0]
   {
      IPA_OFS_PLAIN   = 3'h0,
      IPA_OFS_POST_INCREMENT_OPERAND = 3'h1,
      IPA_OFS_POST_DECREMENT_OPERAND = 3'h2,
      IPA_OFS_PRE_INCREMENT_OPERAND  = 3'h3,
      IPA_OFS_INDEXED = 3'h4,
      IPA_OFS_HIGH    = 3'h5,
      IPA_OFS_LOW     = 3'h6
   } ipa_ofs_e;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [11:0] ipa_group_base(input logic [1:0] pair);
      logic [11:0] base;
      base = IPA_OPND_ONE_ADDR + IPA_GROUP_STRIDE;
      base = base - (IPA_GROUP_STRIDE * {10'h000, pair});
      return base;
   endfunction

   function automatic logic ipa_is_operand(input ipa_ofs_e ofs);
      return (ofs == IPA_OFS_PLAIN) || (ofs == IPA_OFS_POST_INCREMENT_OPERAND) ||
             (ofs == IPA_OFS_POST_DECREMENT_OPERAND) || (ofs == IPA_OFS_PRE_INCREMENT_OPERAND) ||
             (ofs == IPA_OFS_INDEXED);
   endfunction

endpackage

// [ipa_ptr_calc.sv]
// address former of one pointer access: access address and next pointer
// assumes the caller gates the update with its own request and target checks
`timescale 1ns/1ps
module ipa_ptr_calc
   import ipa_pkg::*;
(
   // pointer and operand kind
   input  wire logic [11:0] ptr_in,
   input  wire ipa_ofs_e    ofs_in,
   input  wire logic [7:0]  acc_in,
   // results
   output logic      [11:0] eff_addr_out,
   output logic      [11:0] ptr_next_out,
   output logic             ptr_upd_out
);

   logic [11:0] ptr_inc;
   logic [11:0] ptr_dec;
   logic [11:0] acc_sext;

   // whole-pair arithmetic, so a low byte wrap carries into the high part
   assign ptr_inc  = ptr_in + 12'h001;
   assign ptr_dec  = ptr_in - 12'h001;
   assign acc_sext = {{(IPA_AW - IPA_DW){acc_in[7]}}, acc_in};

   always_comb
   begin
      eff_addr_out = ptr_in;
      ptr_next_out = ptr_in;
      ptr_upd_out  = 1'b0;
      unique case (ofs_in)
         IPA_OFS_POST_DECREMENT_OPERAND:
         begin
            ptr_next_out = ptr_dec;
            ptr_upd_out  = 1'b1;
         end
         IPA_OFS_POST_INCREMENT_OPERAND:
         begin
            ptr_next_out = ptr_inc;
            ptr_upd_out  = 1'b1;
         end
         IPA_OFS_PRE_INCREMENT_OPERAND:
         begin
            eff_addr_out = ptr_inc;
            ptr_next_out = ptr_inc;
            ptr_upd_out  = 1'b1;
         end
         IPA_OFS_INDEXED:
         begin
            // offset address only; neither pointer nor accumulator moves
            eff_addr_out = ptr_in + acc_sext;
         end
         default:
         begin
            eff_addr_out = ptr_in;
         end
      endcase
   end

endmodule

// [ipa_indirect_unit.sv]
// indirect pointer addressing unit: three pointer pairs and their virtual operands
// assumes the core issues one data access per cycle and that data memory
// answers a read one cycle after mem_req_out, on the same clock
//
// Operation
// - The plain operand addresses the pointer's location and leaves the pointer as it was.
// - The post-decrement operand uses the pointer as address, then lowers it by one.
// - The post-increment operand uses the pointer as address, then raises it by one.
// - The pre-increment operand raises the pointer by one and uses the raised value.
// - The indexed operand addresses the pointer plus the accumulator taken as signed.
// - The indexed operand changes neither the pointer nor the accumulator.
// - Increments and decrements act on the whole pair, carrying from low into high byte.
// - Pointer updates never touch the arithmetic status flags.
// - A read through an operand whose pointer names a virtual operand returns zero.
// - A write through an operand whose pointer names a virtual operand does nothing.
// - A write through a pair's own operand onto its own bytes stores without inc or dec.
// - Virtual operands are never indirect targets; only direct naming triggers them.
// - Pointer bytes are physical registers that direct accesses read and modify.
// - Indirect accesses reach every other register just as direct accesses do.
// - Pointer addresses span the full 12-bit data address width.
`timescale 1ns/1ps
module ipa_indirect_unit
   import ipa_pkg::*;
#(
   parameter int unsigned NUM_PAIRS = IPA_NPAIR
)
(
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   // core data access request
   input  wire logic        req_valid_in,
   input  wire logic        req_we_in,
   input  wire logic [11:0] req_addr_in,
   input  wire logic [7:0]  req_wdata_in,
   input  wire logic [7:0]  acc_in,
   // data memory side
   output logic             mem_req_out,
   output logic             mem_we_out,
   output logic      [11:0] mem_addr_out,
   output logic      [7:0]  mem_wdata_out,
   input  wire logic [7:0]  mem_rdata_in,
   // answer to the core
   output logic             rsp_valid_out,
   output logic      [7:0]  rsp_rdata_out
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge mclk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic      hit;
      logic [1:0] pair;
      ipa_ofs_e  ofs;
   } ipa_dec_s;

   function automatic ipa_dec_s ipa_decode(input logic [11:0] addr);
      ipa_dec_s    d;
      logic [11:0] diff;
      d = '{hit: 1'b0, pair: 2'h0, ofs: IPA_OFS_PLAIN};
      for (int n = 0; n < NUM_PAIRS; n++)
      begin
         diff = ipa_group_base(2'(n)) - addr;
         if (diff < IPA_GROUP_SIZE)
         begin
            d.hit  = 1'b1;
            d.pair = 2'(n);
            d.ofs  = ipa_ofs_e'(diff[2:0]);
         end
      end
      return d;
   endfunction

   function automatic logic [7:0] ipa_byte_rd(input logic [11:0] ptr, input ipa_ofs_e ofs);
      return (ofs == IPA_OFS_HIGH) ? {{(2 * IPA_DW - IPA_AW){1'b0}}, ptr[11:8]} : ptr[7:0];
   endfunction

   function automatic logic [11:0] ipa_byte_wr(input logic [11:0] ptr, input ipa_ofs_e ofs,
                                               input logic [7:0] data);
      return (ofs == IPA_OFS_HIGH) ? {data[IPA_HI_W-1:0], ptr[7:0]} : {ptr[11:8], data};
   endfunction

   // ------------------------------------------------------------
   // pointer pairs and access steering
   // ------------------------------------------------------------
   logic [11:0] ptr_q [NUM_PAIRS];
   logic [11:0] ptr_d [NUM_PAIRS];
   ipa_dec_s    req_dec;
   ipa_dec_s    eff_dec;
   logic [11:0] sel_ptr;
   logic [11:0] eff_addr;
   logic [11:0] ptr_next;
   logic        ptr_upd;
   logic        is_opnd;
   logic        is_ptr_byte;
   logic        eff_virt;
   logic        eff_ptr;
   logic        self_wr;
   logic        mem_go;
   logic [11:0] mem_addr_d;
   logic        loc_go;
   logic [7:0]  loc_data_d;

   assign req_dec     = ipa_decode(req_addr_in);
   assign is_opnd     = req_dec.hit && ipa_is_operand(req_dec.ofs);
   assign is_ptr_byte = req_dec.hit && !ipa_is_operand(req_dec.ofs);
   assign sel_ptr     = ptr_q[req_dec.pair];

   ipa_ptr_calc u_calc
   (
      .ptr_in       (sel_ptr),
      .ofs_in       (req_dec.ofs),
      .acc_in       (acc_in),
      .eff_addr_out (eff_addr),
      .ptr_next_out (ptr_next),
      .ptr_upd_out  (ptr_upd)
   );

   assign eff_dec  = ipa_decode(eff_addr);
   assign eff_virt = eff_dec.hit && ipa_is_operand(eff_dec.ofs);
   assign eff_ptr  = eff_dec.hit && !ipa_is_operand(eff_dec.ofs);
   assign self_wr  = is_opnd && eff_ptr && req_we_in && (eff_dec.pair == req_dec.pair);

   always_comb
   begin
      for (int n = 0; n < NUM_PAIRS; n++)
      begin
         ptr_d[n] = ptr_q[n];
      end
      mem_go     = 1'b0;
      mem_addr_d = req_addr_in;
      loc_go     = 1'b0;
      loc_data_d = 8'h00;
      if (req_valid_in && is_opnd)
      begin
         // a write that lands on a virtual operand is a pure no-op
         if (ptr_upd && !self_wr && !(eff_virt && req_we_in))
         begin
            ptr_d[req_dec.pair] = ptr_next;
         end
         if (eff_virt)
         begin
            loc_go     = !req_we_in;
            loc_data_d = 8'h00;
         end
         else if (eff_ptr)
         begin
            loc_go = !req_we_in;
            loc_data_d = ipa_byte_rd(ptr_q[eff_dec.pair], eff_dec.ofs);
            if (req_we_in)
            begin
               // the stored byte wins over the own pair's inc or dec
               ptr_d[eff_dec.pair] = ipa_byte_wr(ptr_q[eff_dec.pair], eff_dec.ofs,
                                                 req_wdata_in);
            end
         end
         else
         begin
            mem_go     = 1'b1;
            mem_addr_d = eff_addr;
         end
      end
      else if (req_valid_in && is_ptr_byte)
      begin
         loc_go     = !req_we_in;
         loc_data_d = ipa_byte_rd(sel_ptr, req_dec.ofs);
         if (req_we_in)
         begin
            ptr_d[req_dec.pair] = ipa_byte_wr(sel_ptr, req_dec.ofs, req_wdata_in);
         end
      end
      else if (req_valid_in)
      begin
         mem_go = 1'b1;
      end
   end

   // status flags live in the core; this update path has no route to them
   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         for (int n = 0; n < NUM_PAIRS; n++)
         begin
            ptr_q[n] <= IPA_PTR_RESET;
         end
      end
      else
      begin
         for (int n = 0; n < NUM_PAIRS; n++)
         begin
            ptr_q[n] <= ptr_d[n];
         end
      end
   end

   // ------------------------------------------------------------
   // memory port and answer pipeline
   // ------------------------------------------------------------
   logic       s1_valid_q;
   logic       s1_loc_q;
   logic [7:0] s1_data_q;
   logic       s2_valid_q;
   logic       s2_loc_q;
   logic [7:0] s2_data_q;

   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         mem_req_out   <= 1'b0;
         mem_we_out    <= 1'b0;
         mem_addr_out  <= 12'h000;
         mem_wdata_out <= 8'h00;
      end
      else
      begin
         mem_req_out   <= mem_go;
         mem_we_out    <= mem_go && req_we_in;
         mem_addr_out  <= mem_addr_d;
         mem_wdata_out <= req_wdata_in;
      end
   end

   // every request is answered a fixed three cycles later, so local and
   // memory answers never overtake each other
   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         s1_valid_q    <= 1'b0;
         s1_loc_q      <= 1'b0;
         s1_data_q     <= 8'h00;
         s2_valid_q    <= 1'b0;
         s2_loc_q      <= 1'b0;
         s2_data_q     <= 8'h00;
         rsp_valid_out <= 1'b0;
         rsp_rdata_out <= 8'h00;
      end
      else
      begin
         s1_valid_q    <= req_valid_in;
         s1_loc_q      <= !mem_go;
         s1_data_q     <= loc_go ? loc_data_d : 8'h00;
         s2_valid_q    <= s1_valid_q;
         s2_loc_q      <= s1_loc_q;
         s2_data_q     <= s1_data_q;
         rsp_valid_out <= s2_valid_q;
         rsp_rdata_out <= s2_loc_q ? s2_data_q : mem_rdata_in;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic        chk_valid_q;
   logic [1:0]  chk_pair_q;
   ipa_ofs_e    chk_ofs_q;
   logic [11:0] chk_old_q;
   logic [11:0] chk_acc_q;
   logic        chk_opnd_q;
   logic        chk_plain_q;

   always_ff @(posedge mclk_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         chk_valid_q <= 1'b0;
         chk_pair_q  <= 2'h0;
         chk_ofs_q   <= IPA_OFS_PLAIN;
         chk_old_q   <= 12'h000;
         chk_acc_q   <= 12'h000;
         chk_opnd_q  <= 1'b0;
         chk_plain_q <= 1'b0;
      end
      else
      begin
         chk_valid_q <= req_valid_in && is_opnd && !eff_dec.hit;
         chk_pair_q  <= req_dec.pair;
         chk_ofs_q   <= req_dec.ofs;
         chk_old_q   <= sel_ptr;
         chk_acc_q   <= {{(IPA_AW - IPA_DW){acc_in[7]}}, acc_in};
         chk_opnd_q  <= req_valid_in && is_opnd;
         chk_plain_q <= req_valid_in && !req_dec.hit;
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n_q);

   property p_plain_hold;
      chk_valid_q && chk_ofs_q == IPA_OFS_PLAIN |->
         ptr_q[chk_pair_q] == chk_old_q && mem_req_out && mem_addr_out == chk_old_q;
   endproperty
   a_plain_hold: assert property (p_plain_hold) else $error("plain operand moved pointer");

   property p_post_decrement_operand;
      chk_valid_q && chk_ofs_q == IPA_OFS_POST_DECREMENT_OPERAND |->
         ptr_q[chk_pair_q] == chk_old_q - 12'h001 && mem_addr_out == chk_old_q;
   endproperty
   a_post_decrement_operand: assert property (p_post_decrement_operand) else $error("post-decrement wrong");

   property p_post_increment_operand;
      chk_valid_q && chk_ofs_q == IPA_OFS_POST_INCREMENT_OPERAND |->
         ptr_q[chk_pair_q] == chk_old_q + 12'h001 && mem_addr_out == chk_old_q;
   endproperty
   a_post_increment_operand: assert property (p_post_increment_operand) else $error("post-increment wrong");

   property p_pre_increment_operand;
      chk_valid_q && chk_ofs_q == IPA_OFS_PRE_INCREMENT_OPERAND |->
         ptr_q[chk_pair_q] == chk_old_q + 12'h001 && mem_addr_out == chk_old_q + 12'h001;
   endproperty
   a_pre_increment_operand: assert property (p_pre_increment_operand) else $error("pre-increment wrong");

   property p_indexed;
      chk_valid_q && chk_ofs_q == IPA_OFS_INDEXED |->
         mem_addr_out == chk_old_q + chk_acc_q && ptr_q[chk_pair_q] == chk_old_q;
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed access wrong");

   property p_virt_read_zero;
      req_valid_in && is_opnd && eff_virt && !req_we_in |->
         ##3 rsp_valid_out && rsp_rdata_out == 8'h00;
   endproperty
   a_virt_read_zero: assert property (p_virt_read_zero) else $error("virtual read not zero");

   property p_virt_write_nop;
      req_valid_in && is_opnd && eff_virt && req_we_in |=>
         !mem_req_out && ptr_q[chk_pair_q] == chk_old_q;
   endproperty
   a_virt_write_nop: assert property (p_virt_write_nop) else $error("virtual write acted");

   property p_self_write;
      req_valid_in && self_wr && eff_dec.ofs == IPA_OFS_LOW |=>
         ptr_q[chk_pair_q][7:0] == $past(req_wdata_in) && !mem_req_out;
   endproperty
   a_self_write: assert property (p_self_write) else $error("self write not stored");

   property p_direct_low;
      req_valid_in && is_ptr_byte && req_we_in && req_dec.ofs == IPA_OFS_LOW |=>
         ptr_q[chk_pair_q][7:0] == $past(req_wdata_in);
   endproperty
   a_direct_low: assert property (p_direct_low) else $error("direct pointer write lost");

   property p_pass_through;
      chk_plain_q |-> mem_req_out ##2 rsp_valid_out;
   endproperty
   a_pass_through: assert property (p_pass_through) else $error("plain access not passed");

   c_post_increment_operand:  cover property (chk_valid_q && chk_ofs_q == IPA_OFS_POST_INCREMENT_OPERAND);
   c_indexed:  cover property (chk_valid_q && chk_ofs_q == IPA_OFS_INDEXED && chk_acc_q[11]);
   c_virt_rd:  cover property (req_valid_in && is_opnd && eff_virt && !req_we_in);
   c_self_wr:  cover property (req_valid_in && self_wr);

endmodule

// [ipa_mem_model.sv]
// data memory model on the far side of the indirect addressing unit
// assumes read data is wanted in the cycle after the request, same clock
`timescale 1ns/1ps
module ipa_mem_model
(
   // clock
   input  wire logic        mclk_in,
   // memory request
   input  wire logic        mem_req_in,
   input  wire logic        mem_we_in,
   input  wire logic [11:0] mem_addr_in,
   input  wire logic [7:0]  mem_wdata_in,
   // read data
   output logic      [7:0]  mem_rdata_out
);
   logic [7:0] mem_q [4096];

   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem_q[i] = 8'(i) ^ {2{4'(i >> 8)}};
      mem_rdata_out = 8'h00;
   end

   // data stands one cycle only; otherwise it flips so a late sample shows
   always @(posedge mclk_in)
   begin
      if (mem_req_in && mem_we_in)
         mem_q[mem_addr_in] <= mem_wdata_in;
      if (mem_req_in && !mem_we_in)
         mem_rdata_out <= mem_q[mem_addr_in];
      else
         mem_rdata_out <= ~mem_rdata_out;
   end
endmodule

// [testbench.sv]
// self-checking bench of the indirect pointer addressing unit
// assumes the data memory model answers one cycle after each request
`timescale 1ns/1ps
module testbench;
   typedef struct { logic we; logic [7:0] d; int t; } ipa_exp_s;
   // drive edge to sampling edge of the answer: one to take, three to answer
   localparam int RSP_LAT = 4;

   logic        mclk_in      = 1'b0;
   logic        rstn_in      = 1'b0;
   logic        req_valid_in = 1'b0;
   logic        req_we_in    = 1'b0;
   logic [11:0] req_addr_in  = 12'h000;
   logic [7:0]  req_wdata_in = 8'h00;
   logic [7:0]  acc_in       = 8'h00;
   logic        mem_req_out;
   logic        mem_we_out;
   logic        rsp_valid_out;
   logic [11:0] mem_addr_out;
   logic [7:0]  mem_wdata_out;
   logic [7:0]  mem_rdata_in;
   logic [7:0]  rsp_rdata_out;
   int          error_cnt = 0;
   int          checks    = 0;
   int          cyc       = 0;
   int          seed      = 32'h1588E3C4;
   logic [11:0] ptr_m [3];
   logic [7:0]  mem_m [4096];
   ipa_exp_s    exp_q [$];
   ipa_exp_s    mon_e;

   always #50 mclk_in = ~mclk_in;
   always @(posedge mclk_in) cyc <= cyc + 1;

   ipa_indirect_unit #(.NUM_PAIRS(3)) DUT (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .req_valid_in(req_valid_in),
      .req_we_in(req_we_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .acc_in(acc_in), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
      .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
      .mem_rdata_in(mem_rdata_in), .rsp_valid_out(rsp_valid_out),
      .rsp_rdata_out(rsp_rdata_out));

   ipa_mem_model mem_u (
      .mclk_in(mclk_in), .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
      .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_rdata_out(mem_rdata_in));

   // ------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------
   function automatic logic [11:0] ga(input int p, input int k);
      return 12'hFEF - 12'(8 * p + k);
   endfunction

   // offset within a pair's group, or -1 for ordinary memory
   function automatic int grp(input logic [11:0] a, output int p);
      p = 0;
      for (int i = 0; i < 3; i++)
         if (ga(i, 0) - a < 12'h007)
         begin
            p = i;
            return int'(ga(i, 0) - a);
         end
      return -1;
   endfunction

   function automatic logic [7:0] pb(input logic we, input int q, input int k,
                                     input logic [7:0] wd);
      if (we && k == 5)
         ptr_m[q][11:8] = wd[3:0];
      if (we && k == 6)
         ptr_m[q][7:0] = wd;
      return (k == 5) ? {4'h0, ptr_m[q][11:8]} : ptr_m[q][7:0];
   endfunction

   function automatic logic [7:0] model(input logic we, input logic [11:0] a,
                                        input logic [7:0] wd, input logic [7:0] acc);
      int          p;
      int          q;
      int          k;
      int          kq;
      logic [11:0] eff;
      logic [11:0] nxt;
      logic [7:0]  rd;
      rd = 8'h00;
      k  = grp(a, p);
      if (k < 0)
      begin
         if (we) mem_m[a] = wd;
         return mem_m[a];
      end
      if (k > 4)
         return pb(we, p, k, wd);
      eff = ptr_m[p] + ((k == 3) ? 12'h001 : 12'h000);
      if (k == 4)
         eff = eff + {{4{acc[7]}}, acc};
      nxt = ptr_m[p] + ((k == 1 || k == 3) ? 12'h001 : (k == 2) ? 12'hFFF : 12'h000);
      kq  = grp(eff, q);
      if (kq >= 0 && kq < 5)
      begin
         if (!we) ptr_m[p] = nxt;
         return 8'h00;
      end
      if (kq > 4)
         rd = pb(we, q, kq, wd);
      else if (we)
         mem_m[eff] = wd;
      else
         rd = mem_m[eff];
      if (!(we && kq > 4 && q == p))
         ptr_m[p] = nxt;
      return rd;
   endfunction

   // ------------------------------------------------------------
   // drivers and checks
   // ------------------------------------------------------------
   function automatic void chk(input string name, input logic [31:0] e,
                               input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, e, g);
      end
   endfunction

   task automatic op(input logic we, input logic [11:0] a, input logic [7:0] wd,
                     input logic [7:0] acc);
      ipa_exp_s e;
      @(posedge mclk_in);
      req_valid_in <= 1'b1;
      req_we_in    <= we;
      req_addr_in  <= a;
      req_wdata_in <= wd;
      acc_in       <= acc;
      e.we = we;
      e.t  = cyc;
      e.d  = model(we, a, wd, acc);
      exp_q.push_back(e);
   endtask

   // the accumulator keeps moving while idle; it must matter only when indexed
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge mclk_in);
         req_valid_in <= 1'b0;
         acc_in       <= 8'($random(seed));
      end
   endtask

   always @(posedge mclk_in)
   begin
      if (rsp_valid_out === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("answer without request", 32'h0, 32'h1);
         else
         begin
            mon_e = exp_q.pop_front();
            chk("answer latency", 32'(RSP_LAT), 32'(cyc - mon_e.t));
            if (!mon_e.we)
               chk("read data", 32'(mon_e.d), 32'(rsp_rdata_out));
         end
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge mclk_in);
      error_cnt++;
      test_done();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      int          p;
      int          k;
      logic [7:0]  d;
      logic [11:0] a;
      for (int i = 0; i < 3; i++)
         ptr_m[i] = 12'h000;
      for (int i = 0; i < 4096; i++)
         mem_m[i] = 8'(i) ^ {2{4'(i >> 8)}};
      repeat (5) @(posedge mclk_in);
      rstn_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      for (int i = 0; i < 6; i++)
         op(1'b0, ga(i / 2, 5 + i % 2), 8'h00, 8'h00);
      $display("test reset pointers done");
      op(1'b1, ga(1, 5), 8'hF0, 8'h00);
      op(1'b1, ga(1, 6), 8'hFF, 8'h00);
      op(1'b1, ga(1, 1), 8'hA1, 8'h00);
      op(1'b0, ga(1, 5), 8'h00, 8'h00);
      op(1'b0, ga(1, 2), 8'h00, 8'h00);
      op(1'b0, ga(1, 6), 8'h00, 8'h00);
      op(1'b0, ga(1, 3), 8'h00, 8'h00);
      op(1'b0, ga(1, 4), 8'h00, 8'hFF);
      op(1'b0, ga(1, 4), 8'h00, 8'h80);
      op(1'b0, ga(1, 4), 8'h00, 8'h7F);
      op(1'b0, ga(1, 0), 8'h00, 8'h00);
      op(1'b0, ga(1, 6), 8'h00, 8'h00);
      idle(1);
      $display("test pointer updates done");
      op(1'b1, ga(0, 5), 8'h0F, 8'h00);
      op(1'b1, ga(0, 6), 8'hE7, 8'h00);
      op(1'b0, ga(0, 0), 8'h00, 8'h00);
      op(1'b1, ga(0, 0), 8'h55, 8'h00);
      op(1'b1, ga(0, 1), 8'h66, 8'h00);
      op(1'b0, ga(0, 6), 8'h00, 8'h00);
      op(1'b0, ga(0, 1), 8'h00, 8'h00);
      op(1'b1, ga(0, 1), 8'h77, 8'h00);
      op(1'b1, ga(0, 2), 8'h10, 8'h00);
      op(1'b0, ga(0, 6), 8'h00, 8'h00);
      op(1'b0, ga(0, 5), 8'h00, 8'h00);
      op(1'b0, 12'hFE8, 8'h00, 8'h00);
      op(1'b1, ga(2, 5), 8'h0F, 8'h00);
      op(1'b1, ga(2, 6), 8'(ga(1, 6)), 8'h00);
      op(1'b1, ga(2, 1), 8'h40, 8'h00);
      op(1'b0, ga(1, 6), 8'h00, 8'h00);
      op(1'b0, ga(2, 6), 8'h00, 8'h00);
      op(1'b0, ga(2, 0), 8'h00, 8'h00);
      for (int i = 0; i < 3; i++)
         op(1'b1, ga(i, 5), 8'h07, 8'h00);
      idle(1);
      $display("test special targets done");
      // pointers kept below F00h so no random access lands on the operand map
      for (int i = 0; i < 400; i++)
      begin
         p = int'($unsigned($random(seed)) % 3);
         k = int'($unsigned($random(seed)) % 7);
         d = 8'($random(seed));
         if (k == 5)
            d[3:0] = 4'(1 + $unsigned($random(seed)) % 14);
         a = (i % 2 == 1) ? ga(p, k) : 12'($unsigned($random(seed)) % 3840);
         op(1'($random(seed)), a, d, 8'($random(seed)));
         if (d[0])
            idle(1);
      end
      idle(8);
      chk("answers outstanding", 32'h0, 32'(exp_q.size()));
      $display("test random traffic done");
      test_done();
   end
endmodule
